// file: rtl/rctm_offset_store.sv
// holding cell for the measured offset value, cleared to zero by reset
module rctm_offset_store
   import rctm_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // write side
   input  wire logic              wr_en,
   input  wire logic [OFFS_W-1:0] wr_data,
   // read side
   output logic      [OFFS_W-1:0] rd_data
);
   logic [OFFS_W-1:0] cell_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cell_q <= '0;
      end else if (wr_en) begin
         cell_q <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= cell_q;
      end
   end
endmodule

// file: rtl/rctm_pkg.sv
// constants and types shared by the residual current trip monitor
package rctm_pkg;
   // current values in units of 0.1 mA
   localparam int unsigned          CUR_W            = 12;
   localparam logic [CUR_W-1:0]     DC_TRIP_LEVEL    = 12'h03C;  // 6 mA
   localparam logic [CUR_W-1:0]     AC_TRIP_LEVEL    = 12'h12C;  // 30 mA
   localparam logic [CUR_W-1:0]     DC_RECOVERY_LEVEL = 12'h019; // 2.5 mA
   localparam logic [CUR_W-1:0]     AC_RECOVERY_LEVEL = 12'h064; // 10 mA
   // internal test currents, 0.1 mA
   localparam logic [CUR_W-1:0]     TEST_DC_LOW_CUR  = 12'h058;  // 8.8 mA
   localparam logic [CUR_W-1:0]     TEST_DC_HIGH_CUR = 12'h22B;  // 55.5 mA
   localparam logic [CUR_W-1:0]     TEST_AC_FIRST_CUR = 12'h056; // 8.6 mA
   localparam logic [CUR_W-1:0]     TEST_AC_SECOND_CUR = 12'h050; // 8.0 mA
   // clock and timing
   localparam longint unsigned      CLK_HZ           = 25000000;
   localparam longint unsigned      TEST_MIN_US      = 30000;    // 30 ms
   localparam longint unsigned      TEST_MAX_US      = 1200000;  // 1.2 s
   localparam longint unsigned      TEST_MIN_CYC_L   = (TEST_MIN_US * CLK_HZ + 999999) / 1000000;
   localparam longint unsigned      TEST_MAX_CYC_L   = (TEST_MAX_US * CLK_HZ) / 1000000;
   localparam longint unsigned      PWM_HZ           = 8000;
   localparam int unsigned          PWM_PERIOD       = int'(CLK_HZ / PWM_HZ); // 3125
   localparam int unsigned          PWM_W            = 12;
   // duty: 3.33 %/mA -> 333 per-10000 per mA; current in 0.1 mA => 333/10 per unit
   localparam int unsigned          PWM_SCALE_NUM    = 333;
   localparam int unsigned          PWM_SCALE_DEN    = 100000;
   localparam longint unsigned      STEP_US          = 20000;    // self-test phase length
   localparam longint unsigned      STEP_CYC_L       = (STEP_US * CLK_HZ) / 1000000;
   localparam int unsigned          CNT_W            = 26;
   localparam int unsigned          OFFS_W           = 12;
   typedef enum logic [0:0] {
      VAR_IN_CABLE,
      VAR_WALL_BOX
   } rctm_var_e;
   typedef enum {
      ST_IDLE,
      ST_OFFSET,
      ST_INJ_DC,
      ST_INJ_AC,
      ST_RELEASE,
      ST_STORE
   } rctm_state_e;
endpackage

// file: rtl/rctm_top.sv
// output, trip hysteresis, pwm and self-test logic of the residual current monitor
// Overview of operation
// RL1: fault output low unless system fault
// RL2: system fault releases both threshold outputs
// RL3: test starts on low of 30ms..1.2s
// RL4: offset stored and subtracted afterwards
// RL5: too short or long low ignored
// RL6: dc output low only below dc level
// RL7: ac output released forces dc release
// RL8: ac output low only below 30mA
// RL9: 8 kHz pwm, 3.33 %/mA dc
// RL10: reaching trip level releases the output
// RL11: released until below recovery level
// RL12: recovery at 2.5 mA and 10 mA
// RL13: controller checks outputs at three checkpoints
// RL14: checkpoint order dc, ac, then active
// RL15: self-test injects variant test currents
// RL16: controller tests only without residual current
// RL17: controller repeats test periodically
// RL18: width measured falling to rising edge
module rctm_top
   import rctm_pkg::*;
#(
   parameter longint unsigned TEST_MIN_CYC = TEST_MIN_CYC_L,
   parameter longint unsigned TEST_MAX_CYC = TEST_MAX_CYC_L,
   parameter longint unsigned STEP_CYC     = STEP_CYC_L
)
(
   // clock and reset
   input  wire logic             REF_CLK,
   input  wire logic             RSTN,
   // measurement front end, 0.1 mA units
   input  wire logic [CUR_W-1:0] DC_RAW,
   input  wire logic [CUR_W-1:0] AC_RMS,
   input  wire logic             SYS_FAULT,
   input  wire logic             VARIANT_WALL_BOX,
   // test request pin (low active)
   input  wire logic             TEST_REQ_N,
   // fault output, open drain
   output logic                  FAULT_O,
   output logic                  FAULT_OE,
   // threshold outputs, open drain
   output logic                  DC_THRESHOLD_OUTPUT_O,
   output logic                  DC_THRESHOLD_OUTPUT_OE,
   output logic                  AC_THRESHOLD_OUTPUT_O,
   output logic                  AC_THRESHOLD_OUTPUT_OE,
   // monitoring pwm
   output logic                  PWM_O,
   // self-test status
   output logic                  TEST_BUSY,
   output logic [CUR_W-1:0]      TEST_CUR
);
   function automatic logic [CUR_W-1:0] sat_sub(input logic [CUR_W-1:0] a,
                                                input logic [CUR_W-1:0] b);
      sat_sub = (a > b) ? a - b : '0;
   endfunction

   // saturate so a large reading plus test current cannot wrap below a threshold
   function automatic logic [CUR_W-1:0] sat_add(input logic [CUR_W-1:0] a,
                                                input logic [CUR_W-1:0] b);
      logic [CUR_W:0] sum;
      sum     = {1'b0, a} + {1'b0, b};
      sat_add = sum[CUR_W] ? '1 : sum[CUR_W-1:0];
   endfunction

   // offset store
   logic              offs_wr;
   logic [OFFS_W-1:0] offs_wdata;
   logic [OFFS_W-1:0] offs_rdata;

   rctm_offset_store u_store (
      .clk     (REF_CLK),
      .rst_n   (RSTN),
      .wr_en   (offs_wr),
      .wr_data (offs_wdata),
      .rd_data (offs_rdata)
   );

   // self-test state
   rctm_state_e       state_q;
   logic [CNT_W-1:0]  step_q;
   logic [CNT_W-1:0]  low_cnt_q;
   logic              req_d1_q;
   logic              start_q;
   logic              test_on;

   assign test_on = (state_q != ST_IDLE);

   // corrected currents: offset removed outside the test, test current added during it
   logic [CUR_W-1:0]  dc_cur;
   logic [CUR_W-1:0]  ac_cur;

   always_comb begin
      dc_cur = sat_sub(DC_RAW, offs_rdata); // RL4
      ac_cur = AC_RMS;
      if (test_on) begin
         dc_cur = DC_RAW;
         if (VARIANT_WALL_BOX) begin
            ac_cur = sat_add(AC_RMS, TEST_CUR); // RL15
         end else begin
            dc_cur = sat_add(DC_RAW, TEST_CUR); // RL15
         end
      end
   end

   // low pulse width from falling to rising edge of the request pin
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         req_d1_q <= 1'b1;
      end else begin
         req_d1_q <= TEST_REQ_N;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         low_cnt_q <= '0;
      end else if (!TEST_REQ_N) begin
         // saturate so an overlong hold cannot wrap back into the window
         if (low_cnt_q <= CNT_W'(TEST_MAX_CYC)) begin
            low_cnt_q <= low_cnt_q + 1'b1; // RL18
         end
      end else begin
         low_cnt_q <= '0;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         start_q <= 1'b0;
      end else begin
         // a release while a test runs is dropped, not queued for later
         // release edge; windows outside 30 ms..1.2 s are dropped
         start_q <= TEST_REQ_N && !req_d1_q && !test_on
                    && (low_cnt_q >= CNT_W'(TEST_MIN_CYC))
                    && (low_cnt_q <= CNT_W'(TEST_MAX_CYC)); // RL3 RL5 RL18
      end
   end

   // test sequence: offset capture, dc trip, ac trip, release, store
   logic step_done;
   assign step_done = (step_q >= CNT_W'(STEP_CYC - 1));

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_q <= ST_IDLE;
         step_q  <= '0;
      end else begin
         step_q <= step_done ? '0 : step_q + 1'b1;
         case (state_q)
            ST_IDLE: begin
               step_q <= '0;
               if (start_q) begin
                  state_q <= ST_OFFSET; // RL3
               end
            end
            ST_OFFSET: begin
               if (step_done) begin
                  state_q <= ST_INJ_DC;
               end
            end
            ST_INJ_DC: begin
               if (step_done) begin
                  state_q <= ST_INJ_AC;
               end
            end
            ST_INJ_AC: begin
               if (step_done) begin
                  state_q <= ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               if (step_done) begin
                  state_q <= ST_STORE;
               end
            end
            ST_STORE: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // offset is sampled at the end of the quiet phase and written at the end of the test
   logic [OFFS_W-1:0] offs_meas_q;

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         offs_meas_q <= '0;
      end else if (state_q == ST_OFFSET && step_done) begin
         offs_meas_q <= DC_RAW;
      end
   end

   assign offs_wr    = (state_q == ST_STORE); // RL4
   assign offs_wdata = offs_meas_q;

   // test current injected per phase
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         TEST_CUR <= '0;
      end else begin
         case (state_q)
            ST_INJ_DC: TEST_CUR <= VARIANT_WALL_BOX ? TEST_AC_FIRST_CUR
                                                    : TEST_DC_LOW_CUR; // RL15
            ST_INJ_AC: TEST_CUR <= VARIANT_WALL_BOX ? TEST_AC_SECOND_CUR
                                                    : TEST_DC_HIGH_CUR; // RL15
            default:   TEST_CUR <= '0;
         endcase
      end
   end

   // checkpoints seen by the controller: dc released, ac released, then active
   // flags lag the state by one cycle; the controller samples mid-phase
   logic force_dc_q;
   logic force_ac_q;

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         force_dc_q <= 1'b0;
         force_ac_q <= 1'b0;
      end else begin
         force_dc_q <= (state_q == ST_INJ_DC) || (state_q == ST_INJ_AC); // RL14
         force_ac_q <= (state_q == ST_INJ_AC); // RL14
      end
   end

   // trip hysteresis
   logic dc_trip_q;
   logic ac_trip_q;

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         dc_trip_q <= 1'b0;
      end else if (dc_cur >= DC_TRIP_LEVEL) begin
         dc_trip_q <= 1'b1; // RL10
      end else if (dc_cur < DC_RECOVERY_LEVEL) begin
         dc_trip_q <= 1'b0; // RL11 RL12
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ac_trip_q <= 1'b0;
      end else if (ac_cur >= AC_TRIP_LEVEL) begin
         ac_trip_q <= 1'b1; // RL10
      end else if (ac_cur < AC_RECOVERY_LEVEL) begin
         ac_trip_q <= 1'b0; // RL11 RL12
      end
   end

   // output drive; faults act combinationally so a fault is never delayed
   logic ac_active;
   logic dc_active;

   assign ac_active = !SYS_FAULT && !ac_trip_q && !force_ac_q; // RL2 RL8
   assign dc_active = ac_active && !SYS_FAULT && !dc_trip_q && !force_dc_q; // RL6 RL7

   assign FAULT_O                = 1'b0;
   assign FAULT_OE               = !SYS_FAULT; // RL1
   assign AC_THRESHOLD_OUTPUT_O  = 1'b0;
   assign AC_THRESHOLD_OUTPUT_OE = ac_active; // RL8
   assign DC_THRESHOLD_OUTPUT_O  = 1'b0;
   assign DC_THRESHOLD_OUTPUT_OE = dc_active; // RL6
   assign TEST_BUSY              = test_on;

   // pwm: duty in clocks = dc_cur * 3125 * 333 / 100000
   logic [PWM_W-1:0] pwm_cnt_q;
   logic [PWM_W-1:0] duty_q;
   logic [31:0]      duty_calc;

   always_comb begin
      duty_calc = (32'(dc_cur) * 32'(PWM_PERIOD) * 32'(PWM_SCALE_NUM)) / 32'(PWM_SCALE_DEN);
      if (duty_calc > 32'(PWM_PERIOD)) begin
         duty_calc = 32'(PWM_PERIOD);
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pwm_cnt_q <= '0;
         duty_q    <= '0;
      end else if (pwm_cnt_q == PWM_W'(PWM_PERIOD - 1)) begin
         pwm_cnt_q <= '0;
         // duty only updates at period start to avoid glitching pulses
         duty_q    <= duty_calc[PWM_W-1:0]; // RL9
      end else begin
         pwm_cnt_q <= pwm_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         PWM_O <= 1'b0;
      end else begin
         PWM_O <= (pwm_cnt_q < duty_q); // RL9
      end
   end
endmodule

// file: verif/rctm_ctrl_model.sv
// supervising controller model: test request driver and pulled-up pins
module rctm_ctrl_model #(
   parameter int STEP_CYC = 8
)
(
   // clock
   input  wire logic clk,
   // open-drain outputs of the monitor
   input  wire logic fault_o,
   input  wire logic fault_oe,
   input  wire logic dc_o,
   input  wire logic dc_oe,
   input  wire logic ac_o,
   input  wire logic ac_oe,
   // request and pin levels
   output logic      test_req_n,
   output wire logic fault_pin,
   output wire logic dc_pin,
   output wire logic ac_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // pull-ups: a released pin reads high
   assign fault_pin = fault_oe ? fault_o : 1'b1;
   assign dc_pin    = dc_oe ? dc_o : 1'b1;
   assign ac_pin    = ac_oe ? ac_o : 1'b1;
   initial test_req_n = 1'b1;
   task automatic pulse(input int n);
      @(posedge clk);
      test_req_n <= 1'b0;
      repeat (n) @(posedge clk);
      test_req_n <= 1'b1;
   endtask
   // pins are read mid-phase so a one-cycle skew cannot flip the result
   task automatic run_test(input int n, output logic [2:0] seen);
      pulse(n);
      repeat (3 + STEP_CYC + STEP_CYC / 2) @(posedge clk);
      #1 seen[0] = dc_pin;
      repeat (STEP_CYC) @(posedge clk);
      #1 seen[1] = ac_pin;
      repeat (STEP_CYC) @(posedge clk);
      #1 seen[2] = !dc_pin && !ac_pin;
      repeat (STEP_CYC) @(posedge clk);
   endtask
endmodule

// file: verif/rctm_props.sv
// port assertions of the residual current trip monitor
module rctm_props
   import rctm_pkg::*;
#(
   parameter longint unsigned TEST_MIN_CYC = 10,
   parameter longint unsigned TEST_MAX_CYC = 40,
   parameter longint unsigned STEP_CYC     = 8
)
(
   // clock, reset and inputs
   input wire logic             REF_CLK,
   input wire logic             RSTN,
   input wire logic [CUR_W-1:0] DC_RAW,
   input wire logic [CUR_W-1:0] AC_RMS,
   input wire logic             SYS_FAULT,
   input wire logic             TEST_REQ_N,
   // outputs
   input wire logic             FAULT_O,
   input wire logic             FAULT_OE,
   input wire logic             DC_THRESHOLD_OUTPUT_OE,
   input wire logic             AC_THRESHOLD_OUTPUT_OE,
   input wire logic             TEST_BUSY
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RSTN);
   logic [31:0] low_q;
   logic [31:0] busy_q;
   logic        dc_oe, ac_oe, quiet;
   assign dc_oe = DC_THRESHOLD_OUTPUT_OE;
   assign ac_oe = AC_THRESHOLD_OUTPUT_OE;
   assign quiet = !SYS_FAULT && DC_RAW < DC_RECOVERY_LEVEL && AC_RMS < AC_RECOVERY_LEVEL;
   // saturating, so an endless low never wraps back into the window
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) low_q <= '0;
      else if (TEST_REQ_N) low_q <= '0;
      else if (low_q != 32'h0000FFFF) low_q <= low_q + 32'h1;
   end
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) busy_q <= '0;
      else busy_q <= TEST_BUSY ? busy_q + 32'h1 : 32'h0;
   end
   sequence s_req_ok;
      TEST_REQ_N && low_q >= TEST_MIN_CYC && low_q <= TEST_MAX_CYC && !TEST_BUSY;
   endsequence
   sequence s_req_bad;
      TEST_REQ_N && low_q != 0 && (low_q < TEST_MIN_CYC || low_q > TEST_MAX_CYC) && !TEST_BUSY;
   endsequence
   AST_FAULT_PIN: assert property (FAULT_OE == !SYS_FAULT && FAULT_O == 1'b0)
      else $error("fault output does not follow the system fault");
   AST_FAULT_RELEASE: assert property (SYS_FAULT |-> !dc_oe && !ac_oe)
      else $error("threshold output driven during a system fault");
   AST_AC_FORCES_DC: assert property (!ac_oe |-> !dc_oe)
      else $error("dc output driven while ac output released");
   AST_AC_TRIP: assert property (AC_RMS >= AC_TRIP_LEVEL |=> !ac_oe)
      else $error("ac output not released at trip level");
   AST_DC_TRIP: assert property (DC_RAW >= DC_TRIP_LEVEL + 12'h010 |=> !dc_oe)
      else $error("dc output not released at trip level");
   AST_HOLD: assert property (!ac_oe && quiet == 1'b0 && !SYS_FAULT && !TEST_BUSY
      && AC_RMS >= AC_RECOVERY_LEVEL |=> !ac_oe)
      else $error("ac output recovered above recovery level");
   AST_RECOVER: assert property ((quiet && !TEST_BUSY) [*2] |-> dc_oe && ac_oe)
      else $error("outputs not driven below recovery level");
   AST_START: assert property (s_req_ok |-> ##1 !TEST_BUSY ##1 TEST_BUSY)
      else $error("qualified request did not start a test");
   AST_IGNORE: assert property (s_req_bad |-> ##2 !TEST_BUSY)
      else $error("unqualified request started a test");
   AST_LENGTH: assert property ($fell(TEST_BUSY) |-> busy_q == 4 * STEP_CYC + 1)
      else $error("self-test length wrong");
   AST_CHECKPOINTS: assert property (TEST_BUSY && quiet |->
      (busy_q < STEP_CYC + 2 || busy_q > 2 * STEP_CYC - 2 || (!dc_oe && ac_oe)) &&
      (busy_q < 2 * STEP_CYC + 2 || busy_q > 3 * STEP_CYC - 2 || !ac_oe) &&
      (busy_q < 3 * STEP_CYC + 2 || busy_q > 4 * STEP_CYC - 2 || (dc_oe && ac_oe)))
      else $error("self-test output sequence wrong");
endmodule
bind rctm_top rctm_props #(
   .TEST_MIN_CYC(TEST_MIN_CYC), .TEST_MAX_CYC(TEST_MAX_CYC), .STEP_CYC(STEP_CYC)
) u_props (
   .REF_CLK(REF_CLK), .RSTN(RSTN), .DC_RAW(DC_RAW), .AC_RMS(AC_RMS),
   .SYS_FAULT(SYS_FAULT), .TEST_REQ_N(TEST_REQ_N), .FAULT_O(FAULT_O), .FAULT_OE(FAULT_OE),
   .DC_THRESHOLD_OUTPUT_OE(DC_THRESHOLD_OUTPUT_OE),
   .AC_THRESHOLD_OUTPUT_OE(AC_THRESHOLD_OUTPUT_OE), .TEST_BUSY(TEST_BUSY));

// file: verif/tb_residual_current_trip_monitor.sv
// self-checking bench of the residual current trip monitor
module tb_residual_current_trip_monitor
   import rctm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TMIN = 10;
   localparam int TMAX = 40;
   localparam int STEP = 8;
   logic             clk = 1'b0, rstn = 1'b0, fault = 1'b0, wall = 1'b0;
   logic [CUR_W-1:0] dc = '0, ac = '0, tcur;
   logic             fo, foe, dco, dcoe, aco, acoe, pwm, busy, req_n, fpin, dpin, apin;
   logic [2:0]       seen;
   logic [31:0]      rng = 32'hDA79;
   logic             dt = 1'b0, at = 1'b0, prev;
   int               mismatches = 0, checks_done = 0, n, hi, rises;
   int               lens[4] = '{TMIN - 1, TMIN, TMAX, TMAX + 1};
   logic [23:0]      corner[8] = '{24'h03B000, 24'h03C000, 24'h019000, 24'h018000,
                                   24'h00012B, 24'h00012C, 24'h03C064, 24'h000063};
   initial begin
      forever #20 clk = ~clk;
   end
   rctm_top #(.TEST_MIN_CYC(TMIN), .TEST_MAX_CYC(TMAX), .STEP_CYC(STEP)) DUT (
      .REF_CLK(clk), .RSTN(rstn), .DC_RAW(dc), .AC_RMS(ac), .SYS_FAULT(fault),
      .VARIANT_WALL_BOX(wall), .TEST_REQ_N(req_n), .FAULT_O(fo), .FAULT_OE(foe),
      .DC_THRESHOLD_OUTPUT_O(dco), .DC_THRESHOLD_OUTPUT_OE(dcoe),
      .AC_THRESHOLD_OUTPUT_O(aco), .AC_THRESHOLD_OUTPUT_OE(acoe), .PWM_O(pwm),
      .TEST_BUSY(busy), .TEST_CUR(tcur));
   rctm_ctrl_model #(.STEP_CYC(STEP)) model (
      .clk(clk), .fault_o(fo), .fault_oe(foe), .dc_o(dco), .dc_oe(dcoe), .ac_o(aco),
      .ac_oe(acoe), .test_req_n(req_n), .fault_pin(fpin), .dc_pin(dpin), .ac_pin(apin));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] r;
      r = s ^ (s << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction
   function automatic int duty(input int cur);
      return cur * int'(PWM_PERIOD) * int'(PWM_SCALE_NUM) / int'(PWM_SCALE_DEN);
   endfunction
   task automatic check(input string what, input logic [31:0] seen_v, input logic [31:0] exp_v);
      checks_done++;
      if (seen_v !== exp_v) begin
         mismatches++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp_v, seen_v);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wait_idle();
      for (n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk);
      if (n == 100) begin
         mismatches++;
         end_of_test();
      end
   endtask
   // reference hysteresis flags follow the levels applied
   task automatic apply(input logic [CUR_W-1:0] d, input logic [CUR_W-1:0] a, input logic f);
      @(posedge clk);
      dc <= d;
      ac <= a;
      fault <= f;
      at = (a >= AC_TRIP_LEVEL) || (at && a >= AC_RECOVERY_LEVEL);
      dt = (d >= DC_TRIP_LEVEL) || (dt && d >= DC_RECOVERY_LEVEL);
      repeat (2) @(posedge clk);
      #1 check("fault pin", fpin, f);
      check("ac oe", acoe, !f && !at);
      check("dc oe", dcoe, !f && !at && !dt);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      check("reset busy", busy, 1'b0);
      check("reset cur", tcur, 12'h000);
      check("reset pwm", pwm, 1'b0);
      check("reset fault", foe, 1'b1);
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      foreach (corner[i]) apply(corner[i][23:12], corner[i][11:0], 1'b0);
      repeat (200) begin
         rng = xs(rng);
         apply({5'h00, rng[6:0]}, {3'h0, rng[16:8]}, rng[20:18] == 3'h0);
      end
      $display("threshold test done");
      apply(12'h01E, 12'h000, 1'b0);
      repeat (PWM_PERIOD) @(posedge clk);
      hi = 0;
      rises = 0;
      prev = pwm;
      repeat (2 * PWM_PERIOD) begin
         @(posedge clk);
         hi += int'(pwm);
         rises += int'(pwm && !prev);
         prev = pwm;
      end
      check("pwm high", hi, 2 * duty(30));
      check("pwm rises", rises, 2);
      $display("pwm test done");
      apply(12'h000, 12'h000, 1'b0);
      foreach (lens[i]) begin
         wall <= i[1];
         if (lens[i] >= TMIN && lens[i] <= TMAX) begin
            fork
               model.run_test(lens[i], seen);
               begin
                  repeat (lens[i] + 16) @(posedge clk);
                  #1 check("cur 1", tcur, i[1] ? TEST_AC_FIRST_CUR : TEST_DC_LOW_CUR);
                  repeat (STEP) @(posedge clk);
                  #1 check("cur 2", tcur, i[1] ? TEST_AC_SECOND_CUR : TEST_DC_HIGH_CUR);
               end
            join
            check("checkpoints", seen, 3'h7);
         end else begin
            model.pulse(lens[i]);
            repeat (4) @(posedge clk);
            #1 check("ignored", busy, 1'b0);
         end
      end
      model.pulse(20);
      repeat (4) @(posedge clk);
      #1 check("busy", busy, 1'b1);
      model.pulse(TMIN);
      wait_idle();
      repeat (4) @(posedge clk);
      #1 check("retrigger", busy, 1'b0);
      apply(12'h00A, 12'h000, 1'b0);
      model.run_test(TMIN, seen);
      check("checkpoints", seen, 3'h7);
      dc <= 12'h045;
      repeat (3) @(posedge clk);
      #1 check("offset 69", dcoe, 1'b1);
      dc <= 12'h046;
      repeat (3) @(posedge clk);
      #1 check("offset 70", dcoe, 1'b0);
      $display("self-test done");
      end_of_test();
   end
endmodule
